// *** hdl/acc_ctrl.v ***
/*
 Analog comparator control: two special function registers, result
 sampling, trigger detection with optional debounce, match flag, interrupt
 and wake-up requests.
 Assumes a CPU register port on clk_sys, analog levels as 8-bit codes,
 a one-cycle Timer 1 overflow pulse, and idle/power-down state inputs.
*/
// How it works
// - Result is 1 when selected plus level exceeds selected minus level.
// - Plus select bits 1:0 route one of four plus pins.
// - Minus bits 7:4: zero picks minus pin, else n/16 of supply.
// - Control bit 5 reads current result; writes to it are ignored.
// - Enable bit 3 runs comparator; clear forces result low, blocks flag.
// - Flag bit 4 set by hardware on trigger match; cleared by software.
// - Modes 000 low, 001 rise, 100 fall, 101 toggle, 111 high.
// - Modes 010, 011, 110 are debounced toggle, rise and fall.
// - Raw compare output is sampled every system clock cycle.
// - Debounce waits two timer overflows, resamples, sets flag if matching.
// - Control bit 7 keeps comparator running in idle when set.
// - Control bit 6 keeps comparator running in power-down when set.
// - Enabled comparator and irq give wake-up from allowed low-power state.
// - Power-down wake-up only in low-level or high-level modes.
// - Interrupt request is match flag gated by enable bit 6.
`timescale 1ns/1ps
`default_nettype none
`include "acc_defines.vh"

module acc_ctrl (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [7:0] interrupt_enable_reg,
  input wire [7:0] plus_pin_0,
  input wire [7:0] plus_pin_1,
  input wire [7:0] plus_pin_2,
  input wire [7:0] plus_pin_3,
  input wire [7:0] minus_pin,
  input wire timer1_overflow,
  input wire idle_state,
  input wire powerdown_state,
  output wire compare_result,
  output wire comparator_irq,
  output wire wakeup_req
);

  localparam DB_IDLE = 1'b0;
  localparam DB_WAIT = 1'b1;

  reg idle_run_enable_reg;
  reg powerdown_run_enable_reg;
  reg match_flag_reg;
  reg match_flag_next;
  reg comparator_enable_reg;
  reg [2:0] trigger_mode_sel_reg;
  reg [3:0] minus_ref_select_reg;
  reg [1:0] plus_select_reg;
  reg sample_reg;
  reg prev_reg;
  reg db_state_reg;
  reg db_expect_reg;
  reg [1:0] db_count_reg;
  reg event_hit;
  reg db_start;
  reg db_fire;

  wire [7:0] plus_level;
  wire [7:0] minus_level;
  wire running;
  wire raw_result;
  wire rise;
  wire fall;
  wire ctrl_wr;
  wire sel_wr;
  wire [7:0] ctrl_read;
  wire [7:0] sel_read;
  wire level_mode;
  wire comparator_irq_enable;

  acc_input_mux u_mux (
    .plus_select(plus_select_reg),
    .minus_ref_select(minus_ref_select_reg),
    .plus_pin_0(plus_pin_0),
    .plus_pin_1(plus_pin_1),
    .plus_pin_2(plus_pin_2),
    .plus_pin_3(plus_pin_3),
    .minus_pin(minus_pin),
    .plus_level(plus_level),
    .minus_level(minus_level)
  );

  // Gating by enable and low-power run bits
  assign running = comparator_enable_reg &
                   (~idle_state | idle_run_enable_reg) &
                   (~powerdown_state | powerdown_run_enable_reg);

  // Compare, forced low when not enabled
  assign raw_result = running & (plus_level > minus_level);

  assign ctrl_wr = reg_wr & (reg_addr == `ACC_CTRL_ADDR);
  assign sel_wr = reg_wr & (reg_addr == `ACC_SEL_ADDR);

  // Sample every clock cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sample_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sample_reg <= raw_result;
      prev_reg <= sample_reg;
    end
  end

  assign compare_result = sample_reg;
  assign rise = sample_reg & ~prev_reg;
  assign fall = ~sample_reg & prev_reg;

  // Trigger mode decode
  always @* begin
    event_hit = 1'b0;
    db_start = 1'b0;
    case (trigger_mode_sel_reg)
      `ACC_MODE_LOW: event_hit = ~sample_reg;
      `ACC_MODE_RISE: event_hit = rise;
      `ACC_MODE_FALL: event_hit = fall;
      `ACC_MODE_TOG: event_hit = rise | fall;
      `ACC_MODE_HIGH: event_hit = sample_reg;
      `ACC_MODE_TOG_DB: db_start = rise | fall;
      `ACC_MODE_RISE_DB: db_start = rise;
      `ACC_MODE_FALL_DB: db_start = fall;
      default: event_hit = 1'b0;
    endcase
  end

  // Debounce: count two overflows then resample
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      db_state_reg <= DB_IDLE;
      db_expect_reg <= 1'b0;
      db_count_reg <= 2'h0;
    end else begin
      case (db_state_reg)
        DB_IDLE: begin
          if (db_start & running) begin
            db_state_reg <= DB_WAIT;
            db_expect_reg <= sample_reg;
            db_count_reg <= 2'h0;
          end
        end
        DB_WAIT: begin
          if (!running) begin
            db_state_reg <= DB_IDLE;
          end else if (timer1_overflow) begin
            if (db_count_reg + 2'h1 == `ACC_DB_OVF_COUNT) begin
              db_state_reg <= DB_IDLE;
            end
            db_count_reg <= db_count_reg + 2'h1;
          end
        end
        default: db_state_reg <= DB_IDLE;
      endcase
    end
  end

  always @* begin
    db_fire = (db_state_reg == DB_WAIT) & running & timer1_overflow &
              (db_count_reg + 2'h1 == `ACC_DB_OVF_COUNT) &
              (sample_reg == db_expect_reg);
  end

  // Flag: hardware set wins over software clear
  always @* begin
    match_flag_next = match_flag_reg;
    if (ctrl_wr) begin
      match_flag_next = reg_wdata[`ACC_CTRL_FLAG];
    end
    if (running & (event_hit | db_fire)) begin
      match_flag_next = 1'b1;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idle_run_enable_reg <= 1'b0;
      powerdown_run_enable_reg <= 1'b0;
      match_flag_reg <= 1'b0;
      comparator_enable_reg <= 1'b0;
      trigger_mode_sel_reg <= 3'h0;
      minus_ref_select_reg <= 4'h0;
      plus_select_reg <= 2'h0;
    end else begin
      match_flag_reg <= match_flag_next;
      if (ctrl_wr) begin
        // Result bit not writable
        idle_run_enable_reg <= reg_wdata[`ACC_CTRL_IDLE_RUN];
        powerdown_run_enable_reg <= reg_wdata[`ACC_CTRL_PD_RUN];
        comparator_enable_reg <= reg_wdata[`ACC_CTRL_ENABLE];
        trigger_mode_sel_reg <=
          reg_wdata[`ACC_CTRL_MODE_HI:`ACC_CTRL_MODE_LO];
      end
      if (sel_wr) begin
        minus_ref_select_reg <=
          reg_wdata[`ACC_SEL_MINUS_HI:`ACC_SEL_MINUS_LO];
        plus_select_reg <= reg_wdata[`ACC_SEL_PLUS_HI:`ACC_SEL_PLUS_LO];
      end
    end
  end

  // Read views; result bit live
  assign ctrl_read = {idle_run_enable_reg, powerdown_run_enable_reg,
                      sample_reg, match_flag_reg, comparator_enable_reg,
                      trigger_mode_sel_reg};
  assign sel_read = {minus_ref_select_reg, 2'h0, plus_select_reg} &
                    `ACC_SEL_WMASK;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `ACC_CTRL_ADDR) begin
        reg_rdata <= ctrl_read;
      end else if (reg_addr == `ACC_SEL_ADDR) begin
        reg_rdata <= sel_read;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // Interrupt request
  assign comparator_irq_enable = interrupt_enable_reg[`ACC_IE_IRQ_BIT];
  assign comparator_irq = match_flag_reg & comparator_irq_enable;

  // Wake-up, level modes only in power-down
  assign level_mode = (trigger_mode_sel_reg == `ACC_MODE_LOW) |
                      (trigger_mode_sel_reg == `ACC_MODE_HIGH);
  assign wakeup_req = comparator_irq & running &
                      (idle_state | powerdown_state) &
                      (~powerdown_state | level_mode);

endmodule
`default_nettype wire

// *** hdl/acc_defines.vh ***
/*
 Constants for the analog comparator control block: register addresses,
 field positions, reset values, trigger mode codes and debounce overflow count.
 Assumes inclusion by bare name from the design files.
*/
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH

`define ACC_CTRL_ADDR 8'h9e
`define ACC_SEL_ADDR 8'h9f
`define ACC_CTRL_RESET 8'h00
`define ACC_SEL_RESET 8'h00

`define ACC_CTRL_IDLE_RUN 7
`define ACC_CTRL_PD_RUN 6
`define ACC_CTRL_RESULT 5
`define ACC_CTRL_FLAG 4
`define ACC_CTRL_ENABLE 3
`define ACC_CTRL_MODE_HI 2
`define ACC_CTRL_MODE_LO 0

`define ACC_SEL_MINUS_HI 7
`define ACC_SEL_MINUS_LO 4
`define ACC_SEL_PLUS_HI 1
`define ACC_SEL_PLUS_LO 0
`define ACC_SEL_WMASK 8'hf3

`define ACC_IE_IRQ_BIT 6

`define ACC_MODE_LOW 3'h0
`define ACC_MODE_RISE 3'h1
`define ACC_MODE_TOG_DB 3'h2
`define ACC_MODE_RISE_DB 3'h3
`define ACC_MODE_FALL 3'h4
`define ACC_MODE_TOG 3'h5
`define ACC_MODE_FALL_DB 3'h6
`define ACC_MODE_HIGH 3'h7

`define ACC_MINUS_EXT 4'h0
`define ACC_DB_OVF_COUNT 2'h2

`endif

// *** hdl/acc_input_mux.v ***
/*
 Input selection for the comparator: picks one of four plus pins and
 either the minus pin or an internal fraction of supply for the minus side.
 Assumes analog levels arrive as unsigned 8-bit codes on the system clock,
 with the supply represented as full scale 8'hff + 1.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acc_defines.vh"

module acc_input_mux (
  input wire [1:0] plus_select,
  input wire [3:0] minus_ref_select,
  input wire [7:0] plus_pin_0,
  input wire [7:0] plus_pin_1,
  input wire [7:0] plus_pin_2,
  input wire [7:0] plus_pin_3,
  input wire [7:0] minus_pin,
  output reg [7:0] plus_level,
  output wire [7:0] minus_level
);

  // Plus pin routing
  always @* begin
    case (plus_select)
      2'h0: plus_level = plus_pin_0;
      2'h1: plus_level = plus_pin_1;
      2'h2: plus_level = plus_pin_2;
      2'h3: plus_level = plus_pin_3;
      default: plus_level = plus_pin_0;
    endcase
  end

  // Minus pin or n/16 of supply
  assign minus_level = (minus_ref_select == `ACC_MINUS_EXT) ? minus_pin :
                       {minus_ref_select, 4'h0};

endmodule
`default_nettype wire

// *** test/acc_ctrl_monitor.sv ***
/* Checker for acc_ctrl: ties outputs to register writes and inputs.
 Assumes it is bound to the top and sees only the top ports. */
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] interrupt_enable_reg,
  input wire logic [7:0] plus_pin_0,
  input wire logic [7:0] plus_pin_1,
  input wire logic [7:0] plus_pin_2,
  input wire logic [7:0] plus_pin_3,
  input wire logic [7:0] minus_pin,
  input wire logic timer1_overflow,
  input wire logic idle_state,
  input wire logic powerdown_state,
  input wire logic compare_result,
  input wire logic comparator_irq,
  input wire logic wakeup_req
);
  logic [7:0] ctl_reg, sel_reg, plus_v, minus_v;
  logic gt, run;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Shadow of written register fields
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg <= 8'h00;
      sel_reg <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h9e) begin
      ctl_reg <= reg_wdata;
    end else if (reg_wr && reg_addr == 8'h9f) begin
      sel_reg <= reg_wdata;
    end
  end
  assign plus_v = sel_reg[1] ? (sel_reg[0] ? plus_pin_3 : plus_pin_2)
    : (sel_reg[0] ? plus_pin_1 : plus_pin_0);
  assign minus_v = (sel_reg[7:4] == 4'h0) ? minus_pin : {sel_reg[7:4], 4'h0};
  assign gt = plus_v > minus_v;
  assign run = ctl_reg[3] && (!idle_state || ctl_reg[7])
    && (!powerdown_state || ctl_reg[6]);
  a_result_calc: assert property (
    run ##1 run |-> compare_result == $past(gt))
    else $error("compare result wrong");
  a_result_off: assert property (
    !ctl_reg[3] ##1 !ctl_reg[3] |-> !compare_result)
    else $error("result high while disabled");
  a_idle_gate: assert property (
    idle_state && !ctl_reg[7] ##1 idle_state && !ctl_reg[7]
    |-> !compare_result) else $error("result high in gated idle");
  a_pd_gate: assert property (
    powerdown_state && !ctl_reg[6] ##1 powerdown_state && !ctl_reg[6]
    |-> !compare_result) else $error("result high in gated pd");
  a_level_flag: assert property (
    run && ctl_reg[2:0] == 3'h7 && compare_result
    ##1 interrupt_enable_reg[6] |-> comparator_irq)
    else $error("high level did not set flag");
  a_irq_gate: assert property (
    comparator_irq |-> interrupt_enable_reg[6])
    else $error("irq without enable");
  a_wake_cause: assert property (
    wakeup_req |-> interrupt_enable_reg[6] && ctl_reg[3]
    && (idle_state || powerdown_state)) else $error("wake without cause");
  a_wake_pd_mode: assert property (
    wakeup_req && powerdown_state && !idle_state
    |-> ctl_reg[2:0] == 3'h0 || ctl_reg[2:0] == 3'h7)
    else $error("pd wake in edge mode");
  a_sel_reserved: assert property (
    reg_rd && reg_addr == 8'h9f |=> reg_rdata[3:2] == 2'h0)
    else $error("reserved select bits set");
  c_pd_wake: cover property (wakeup_req && powerdown_state);
  c_irq: cover property (comparator_irq);
  c_run_high: cover property (run && compare_result);
endmodule
`default_nettype wire

// *** test/acc_ctrl_tb.sv ***
/* Bench for acc_ctrl: register tasks, compare, mode sweep, low power.
 Assumes the checker file is compiled before this one. */
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_tb;
  localparam logic [7:0] RISE_M = 8'haf;
  localparam logic [7:0] FALL_M = 8'hf5;
  logic clk_sys = 1'b0;
  logic rst_n, reg_wr, reg_rd, timer1_overflow, idle_state;
  logic powerdown_state, compare_result, comparator_irq, wakeup_req;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, interrupt_enable_reg;
  logic [7:0] plus_pin_0, plus_pin_1, plus_pin_2, plus_pin_3, minus_pin;
  int err_total, comparisons, i;
  always #25 clk_sys = ~clk_sys;
  acc_ctrl DUT (.clk_sys, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .interrupt_enable_reg, .plus_pin_0, .plus_pin_1,
    .plus_pin_2, .plus_pin_3, .minus_pin, .timer1_overflow, .idle_state,
    .powerdown_state, .compare_result, .comparator_irq, .wakeup_req);
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tk(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    tk(1);
    reg_wr = 1'b0;
    tk(1);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
    reg_addr = a;
    reg_rd = 1'b1;
    tk(1);
    reg_rd = 1'b0;
    chk(nm, reg_rdata, e);
    tk(1);
  endtask
  // Move plus pin 0, then two timer overflow pulses
  task automatic step(logic [7:0] v);
    plus_pin_0 = v;
    repeat (2) begin
      tk(3);
      timer1_overflow = 1'b1;
      tk(1);
      timer1_overflow = 1'b0;
    end
    tk(3);
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, timer1_overflow, idle_state} = 5'h00;
    {powerdown_state, reg_addr, reg_wdata, interrupt_enable_reg} = 25'h0;
    {plus_pin_0, plus_pin_1, plus_pin_2, plus_pin_3} = 32'h2060a0e0;
    minus_pin = 8'h50;
    tk(2);
    rst_n = 1'b1;
    rd(8'h9e, 8'h00, "ctrl_reset");
    rd(8'h9f, 8'h00, "sel_reset");
    wr(8'h9d, 8'hff);
    wr(8'h9f, 8'hff);
    rd(8'h9f, 8'hf3, "sel_mask");
    rd(8'h9d, 8'h00, "unmapped");
    $display("Test registers done");
    wr(8'h9e, 8'h28);
    for (i = 0; i < 8; i++) begin
      wr(8'h9f, {i[2] ? 4'h0 : 4'h8, 2'h0, i[1:0]});
      tk(2);
      chk("result", compare_result, i[2] ? i[1:0] > 0 : i[1:0] > 1);
    end
    rd(8'h9e, 8'h38, "ctrl_read");
    wr(8'h9e, 8'h00);
    tk(2);
    chk("result_off", compare_result, 8'h00);
    $display("Test compare done");
    wr(8'h9f, 8'h80);
    for (i = 0; i < 8; i++) begin
      wr(8'h9e, {5'h01, i[2:0]});
      wr(8'h9e, {5'h01, i[2:0]});
      tk(2);
      rd(8'h9e, {3'h0, i == 0, 1'b1, i[2:0]}, "flag_low");
      step(8'he0);
      rd(8'h9e, {3'h1, RISE_M[i], 1'b1, i[2:0]}, "flag_rise");
      wr(8'h9e, {5'h01, i[2:0]});
      rd(8'h9e, {3'h1, i == 7, 1'b1, i[2:0]}, "flag_high");
      step(8'h20);
      rd(8'h9e, {3'h0, FALL_M[i], 1'b1, i[2:0]}, "flag_fall");
    end
    wr(8'h9e, 8'h0b);
    plus_pin_0 = 8'he0;
    tk(3);
    step(8'h20);
    rd(8'h9e, 8'h0b, "glitch");
    $display("Test modes done");
    wr(8'h9e, 8'h0f);
    interrupt_enable_reg = 8'h40;
    chk("irq_idle", comparator_irq, 8'h00);
    plus_pin_0 = 8'he0;
    tk(3);
    chk("irq_on", comparator_irq, 8'h01);
    interrupt_enable_reg = 8'h00;
    tk(1);
    chk("irq_masked", comparator_irq, 8'h00);
    interrupt_enable_reg = 8'h40;
    idle_state = 1'b1;
    tk(3);
    chk("idle_gated", compare_result, 8'h00);
    wr(8'h9e, 8'h8f);
    tk(2);
    chk("idle_run", compare_result, 8'h01);
    chk("idle_wake", wakeup_req, 8'h01);
    idle_state = 1'b0;
    powerdown_state = 1'b1;
    wr(8'h9e, 8'h4f);
    tk(2);
    chk("pd_wake", wakeup_req, 8'h01);
    wr(8'h9e, 8'h59);
    chk("pd_flag", comparator_irq, 8'h01);
    chk("pd_edge", wakeup_req, 8'h00);
    wr(8'h9e, 8'h0f);
    tk(2);
    chk("pd_gated", compare_result, 8'h00);
    powerdown_state = 1'b0;
    $display("Test low power done");
    tally_and_finish();
  end
endmodule
bind acc_ctrl acc_ctrl_monitor mon (.clk_sys, .rst_n, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .interrupt_enable_reg, .plus_pin_0,
  .plus_pin_1, .plus_pin_2, .plus_pin_3, .minus_pin, .timer1_overflow,
  .idle_state, .powerdown_state, .compare_result, .comparator_irq,
  .wakeup_req);
`default_nettype wire
